// ===== ssof_host_model.sv
// Purpose: host controller model facing the status flags
// Assumes: host logic runs on the drive clock
// Notes: behavioural; never answers wrongly
`timescale 1ns/1ns
module ssof_host_model (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire ssof_pkg::ssof_flags_t flags_i,
	input wire logic abs_encoder_i,
	output logic encoder_power_on_o,
	output logic servo_on_o,
	output logic step_go_o
);
	import ssof_pkg::*;
	logic [3:0] xfer_q;
	// absolute data goes out first, then encoder power on
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			xfer_q <= 4'h0;
			encoder_power_on_o <= 1'b0;
			servo_on_o <= 1'b0;
			step_go_o <= 1'b0;
		end else begin
			if (abs_encoder_i && xfer_q != 4'hF) xfer_q <= xfer_q + 4'h1;
			encoder_power_on_o <= abs_encoder_i && xfer_q == 4'hF;
			servo_on_o <= flags_i.ready; // servo on only when ready
			step_go_o <= flags_i.speed_match;
		end
	end
endmodule : ssof_host_model

// ===== ssof_pkg.sv
// Purpose: constants and types for the servo status output flags block
// Assumes: one 100 MHz control clock; every clock cycle is one control cycle
// Notes: register offsets are byte addresses on the plain register port
// Behaviour
// - warning output follows any warning condition
// - warning reaches terminal only when allocated
// - rotation flag when speed at or above level
// - rotation level 1 to 10000, default 20
// - ready needs power, no base block, no alarm
// - servo on accepted only while ready
// - speed match when speed error below width
// - speed match only in speed control
// - position done when position error below width
// - done width 0 to 2^30, default 7
// - timing mode 0 uses error only, a write to the apply register applies
// - timing mode 1 also needs filtered reference zero
// - timing mode 2 also needs raw reference zero
// - other flags reach terminals only when allocated
package ssof_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_ALLOC = 8'h00;
	localparam logic [7:0] OFS_MODE = 8'h04;
	localparam logic [7:0] OFS_ROT_LVL = 8'h08;
	localparam logic [7:0] OFS_SPD_W = 8'h0C;
	localparam logic [7:0] OFS_POS_W = 8'h10;
	localparam logic [7:0] OFS_TIMING = 8'h14;
	localparam logic [7:0] OFS_APPLY = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1C;

	// threshold limits and values after reset
	localparam logic [31:0] ROT_LVL_MIN = 32'h0000_0001;
	localparam logic [31:0] ROT_LVL_MAX = 32'h0000_2710;
	localparam logic [31:0] ROT_LVL_RST = 32'h0000_0014;
	localparam logic [31:0] SPD_W_MIN = 32'h0000_0000;
	localparam logic [31:0] SPD_W_MAX = 32'h0000_0064;
	localparam logic [31:0] SPD_W_RST = 32'h0000_000A;
	localparam logic [31:0] POS_W_MIN = 32'h0000_0000;
	localparam logic [31:0] POS_W_MAX = 32'h4000_0000;
	localparam logic [31:0] POS_W_RST = 32'h0000_0007;

	// terminal allocation digits, two bits each, 0 means unallocated
	localparam int SEL_WARN_POS = 0;
	localparam int SEL_ROT_POS = 2;
	localparam int SEL_RDY_POS = 4;
	localparam int SEL_SPD_POS = 6;
	localparam int SEL_DONE_POS = 8;
	localparam logic [9:0] ALLOC_RST = 10'h000;

	// status and timing register field positions
	localparam int STAT_ACCEPT_POS = 5;
	localparam int STAT_TERM_POS = 6;
	localparam int TIMING_ACT_POS = 4;

	typedef enum logic [1:0] {
		CM_SPEED = 2'h0,
		CM_POSITION = 2'h1,
		CM_TORQUE = 2'h2
	} ssof_ctrl_mode_t;
	localparam ssof_ctrl_mode_t MODE_RST = CM_SPEED;

	typedef enum logic [1:0] {
		TM_ERROR_ONLY = 2'h0,
		TM_FILTERED_ZERO = 2'h1,
		TM_INPUT_ZERO = 2'h2
	} ssof_timing_t;
	localparam ssof_timing_t TIMING_RST = TM_ERROR_ONLY;

	// discrete conditions arriving from outside the clock domain
	typedef struct packed {
		logic main_power;
		logic base_block;
		logic alarm;
		logic warning;
		logic abs_encoder;
		logic encoder_power_on;
		logic servo_on;
	} ssof_pins_t;

	// the five status flags
	typedef struct packed {
		logic warning;
		logic rotation;
		logic ready;
		logic speed_match;
		logic position_done;
	} ssof_flags_t;

endpackage : ssof_pkg

// ===== ssof_top.sv
// Purpose: status flags and terminal routing of a servo drive
// Assumes: numeric inputs come from logic on mclk_i; pins_i are asynchronous
// Notes: terminal_o bit high means the output is conducting (closed)
`timescale 1ns/1ns
module ssof_top (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire ssof_pkg::ssof_pins_t pins_i,
	input wire logic signed [15:0] motor_speed_i,
	input wire logic signed [15:0] ref_speed_i,
	input wire logic signed [31:0] position_error_i,
	input wire logic signed [31:0] pos_ref_filtered_i,
	input wire logic signed [31:0] pos_ref_input_i,
	output ssof_pkg::ssof_flags_t flags_o,
	output logic servo_on_accept_o,
	output logic [2:0] terminal_o
);
	import ssof_pkg::*;

	// magnitude of a signed word, -2^31 maps to 2^31
	function automatic logic [31:0] mag32(input logic signed [31:0] v);
		logic [31:0] r;
		r = v[31] ? 32'(-v) : 32'(v);
		return r;
	endfunction : mag32

	// keeps a written value inside its legal range
	function automatic logic [31:0] clamp32(input logic [31:0] v, input logic [31:0] lo,
		input logic [31:0] hi);
		logic [31:0] r;
		r = (v < lo) ? lo : ((v > hi) ? hi : v);
		return r;
	endfunction : clamp32

	// one-hot terminal drive for a flag and its allocation digit
	function automatic logic [2:0] term_map(input logic [1:0] sel, input logic flag);
		logic [2:0] r;
		r = 3'h0;
		unique case (sel)
			2'h0: r = 3'h0;
			2'h1: r = 3'h1;
			2'h2: r = 3'h2;
			2'h3: r = 3'h4;
		endcase
		return flag ? r : 3'h0;
	endfunction : term_map

	ssof_pins_t pin1_q, pin2_q;
	logic [9:0] alloc_q, alloc_d;
	ssof_ctrl_mode_t mode_q, mode_d;
	logic [31:0] rot_lvl_q, rot_lvl_d;
	logic [31:0] spd_w_q, spd_w_d;
	logic [31:0] pos_w_q, pos_w_d;
	ssof_timing_t tm_pend_q, tm_pend_d;
	ssof_timing_t tm_act_q, tm_act_d;
	logic [31:0] rdata_q, rdata_d;
	ssof_flags_t flags_q, flags_d;
	logic accept_q, accept_d;
	logic [2:0] term_q, term_d;
	logic [31:0] speed_mag, speed_err;
	logic ref_zero;

	// two-stage synchroniser for the discrete pins
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			pin1_q <= '0;
			pin2_q <= '0;
		end else begin
			pin1_q <= pins_i;
			pin2_q <= pin1_q;
		end
	end

	// register writes, out-of-range thresholds are clamped, mode and timing value 3 is ignored
	always_comb begin
		alloc_d = alloc_q;
		mode_d = mode_q;
		rot_lvl_d = rot_lvl_q;
		spd_w_d = spd_w_q;
		pos_w_d = pos_w_q;
		tm_pend_d = tm_pend_q;
		tm_act_d = tm_act_q;
		if (wr_i) begin
			case (addr_i)
				OFS_ALLOC: alloc_d = wdata_i[9:0];
				OFS_MODE: begin
					if (wdata_i[1:0] != 2'h3) begin
						mode_d = ssof_ctrl_mode_t'(wdata_i[1:0]);
					end
				end
				OFS_ROT_LVL: rot_lvl_d = clamp32(wdata_i, ROT_LVL_MIN, ROT_LVL_MAX);
				OFS_SPD_W: spd_w_d = clamp32(wdata_i, SPD_W_MIN, SPD_W_MAX);
				OFS_POS_W: pos_w_d = clamp32(wdata_i, POS_W_MIN, POS_W_MAX);
				OFS_TIMING: begin
					if (wdata_i[1:0] != 2'h3) begin
						tm_pend_d = ssof_timing_t'(wdata_i[1:0]);
					end
				end
				OFS_APPLY: tm_act_d = tm_pend_q;
				default: ;
			endcase
		end
	end

	// read mux, data stand only in the cycle after the strobe
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (rd_i) begin
			case (addr_i)
				OFS_ALLOC: rdata_d = {22'h00_0000, alloc_q};
				OFS_MODE: rdata_d = {30'h0000_0000, mode_q};
				OFS_ROT_LVL: rdata_d = rot_lvl_q;
				OFS_SPD_W: rdata_d = spd_w_q;
				OFS_POS_W: rdata_d = pos_w_q;
				OFS_TIMING: rdata_d = {26'h000_0000, tm_act_q, 2'h0, tm_pend_q};
				OFS_STATUS: rdata_d = {23'h00_0000, term_q, accept_q, flags_q};
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// register file and read data
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			alloc_q <= ALLOC_RST;
			mode_q <= MODE_RST;
			rot_lvl_q <= ROT_LVL_RST;
			spd_w_q <= SPD_W_RST;
			pos_w_q <= POS_W_RST;
			tm_pend_q <= TIMING_RST;
			tm_act_q <= TIMING_RST;
			rdata_q <= 32'h0000_0000;
		end else begin
			alloc_q <= alloc_d;
			mode_q <= mode_d;
			rot_lvl_q <= rot_lvl_d;
			spd_w_q <= spd_w_d;
			pos_w_q <= pos_w_d;
			tm_pend_q <= tm_pend_d;
			tm_act_q <= tm_act_d;
			rdata_q <= rdata_d;
		end
	end

	// threshold comparisons, evaluated every control cycle
	always_comb begin
		speed_mag = mag32({{16{motor_speed_i[15]}}, motor_speed_i});
		speed_err = mag32({{16{ref_speed_i[15]}}, ref_speed_i} - {{16{motor_speed_i[15]}}, motor_speed_i});
		unique case (tm_act_q)
			TM_ERROR_ONLY: ref_zero = 1'b1;
			TM_FILTERED_ZERO: ref_zero = (pos_ref_filtered_i == 32'sh0);
			TM_INPUT_ZERO: ref_zero = (pos_ref_input_i == 32'sh0);
			default: ref_zero = 1'b1;
		endcase
		flags_d.warning = pin2_q.warning;
		flags_d.rotation = (speed_mag >= rot_lvl_q);
		flags_d.ready = pin2_q.main_power && !pin2_q.base_block && !pin2_q.alarm
			&& (!pin2_q.abs_encoder || pin2_q.encoder_power_on);
		flags_d.speed_match = (mode_q == CM_SPEED) && (speed_err < spd_w_q);
		flags_d.position_done = (mode_q == CM_POSITION)
			&& (mag32(position_error_i) < pos_w_q) && ref_zero;
		accept_d = flags_d.ready && pin2_q.servo_on;
		term_d = term_map(alloc_q[SEL_WARN_POS +: 2], flags_d.warning)
			| term_map(alloc_q[SEL_ROT_POS +: 2], flags_d.rotation)
			| term_map(alloc_q[SEL_RDY_POS +: 2], flags_d.ready)
			| term_map(alloc_q[SEL_SPD_POS +: 2], flags_d.speed_match)
			| term_map(alloc_q[SEL_DONE_POS +: 2], flags_d.position_done);
	end

	// outputs registered so they change only on clock edges or when reset_i clears them
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			flags_q <= '0;
			accept_q <= 1'b0;
			term_q <= 3'h0;
		end else begin
			flags_q <= flags_d;
			accept_q <= accept_d;
			term_q <= term_d;
		end
	end

	// output drive
	assign rdata_o = rdata_q;
	assign flags_o = flags_q;
	assign servo_on_accept_o = accept_q;
	assign terminal_o = term_q;

	// checks on the flag behaviour
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (reset_i);

	AST_WARN_FOLLOWS: assert property (
		##1 flags_o.warning == $past(pin2_q.warning))
		else $error("warning flag does not follow condition");

	AST_WARN_TERM: assert property (
		flags_o.warning && $past(alloc_q[SEL_WARN_POS +: 2]) == 2'h1 |-> terminal_o[0])
		else $error("allocated warning not on terminal");

	AST_ROT_LEVEL: assert property (
		##1 flags_o.rotation == ($past(speed_mag) >= $past(rot_lvl_q)))
		else $error("rotation flag wrong for speed");

	AST_ROT_RANGE: assert property (
		rot_lvl_q >= ROT_LVL_MIN && rot_lvl_q <= ROT_LVL_MAX)
		else $error("rotation level out of range");

	AST_READY_COND: assert property (
		flags_o.ready |-> $past(pin2_q.main_power) && !$past(pin2_q.alarm)
			&& !$past(pin2_q.base_block))
		else $error("ready without its conditions");

	AST_ACCEPT_READY: assert property (
		servo_on_accept_o |-> flags_o.ready)
		else $error("servo on accepted while not ready");

	AST_SPD_MATCH: assert property (
		!reset_i && !$past(reset_i) && $past(mode_q) == CM_SPEED
			|-> flags_o.speed_match == ($past(speed_err) < $past(spd_w_q)))
		else $error("speed match wrong for error");

	AST_SPD_MODE: assert property (
		flags_o.speed_match |-> $past(mode_q) == CM_SPEED)
		else $error("speed match outside speed control");

	AST_SPD_RANGE: assert property (
		spd_w_q <= SPD_W_MAX)
		else $error("speed match width out of range");

	AST_DONE_WIDTH: assert property (
		flags_o.position_done |-> $past(mode_q) == CM_POSITION
			&& $past(mag32(position_error_i)) < $past(pos_w_q))
		else $error("position done with large error");

	AST_DONE_FILT: assert property (
		flags_o.position_done && $past(tm_act_q) == TM_FILTERED_ZERO |-> $past(pos_ref_filtered_i) == 32'sh0)
		else $error("position done with filtered reference moving");

	AST_DONE_INPUT: assert property (
		flags_o.position_done && $past(tm_act_q) == TM_INPUT_ZERO |-> $past(pos_ref_input_i) == 32'sh0)
		else $error("position done with reference input moving");

	AST_TERM_UNALLOC: assert property (
		$past(alloc_q) == 10'h000 |-> terminal_o == 3'h0)
		else $error("terminal driven with nothing allocated");

	// register port answers, set side of ready and completion, terminal drive
	AST_RDATA_IDLE: assert property (
		!$past(rd_i) |-> rdata_o == 32'h0000_0000)
		else $error("read data present without a read");

	AST_RDATA_ROT: assert property (
		$past(rd_i) && $past(addr_i) == OFS_ROT_LVL |-> rdata_o == $past(rot_lvl_q))
		else $error("rotation level read back wrong");

	AST_READY_ENC: assert property (
		flags_o.ready && $past(pin2_q.abs_encoder) |-> $past(pin2_q.encoder_power_on))
		else $error("ready before encoder power on");

	AST_READY_SET: assert property (
		!reset_i && !$past(reset_i) && $past(pin2_q.main_power) && !$past(pin2_q.base_block)
			&& !$past(pin2_q.alarm) && (!$past(pin2_q.abs_encoder) || $past(pin2_q.encoder_power_on))
			|-> flags_o.ready)
		else $error("ready missing with all conditions met");

	AST_ACCEPT_SET: assert property (
		flags_o.ready && $past(pin2_q.servo_on) |-> servo_on_accept_o)
		else $error("servo on refused while ready");

	AST_DONE_MODE0: assert property (
		!reset_i && !$past(reset_i) && $past(mode_q) == CM_POSITION && $past(tm_act_q) == TM_ERROR_ONLY
			&& $past(mag32(position_error_i)) < $past(pos_w_q) |-> flags_o.position_done)
		else $error("position done missing with small error");

	AST_TIMING_HOLD: assert property (
		!reset_i && !$past(reset_i) && !($past(wr_i) && $past(addr_i) == OFS_APPLY) |-> $stable(tm_act_q))
		else $error("timing mode changed without apply");

	AST_READY_TERM: assert property (
		flags_o.ready && $past(alloc_q[SEL_RDY_POS +: 2]) == 2'h3 |-> terminal_o[2])
		else $error("allocated ready not on terminal");

	AST_DONE_TERM: assert property (
		flags_o.position_done && $past(alloc_q[SEL_DONE_POS +: 2]) == 2'h2 |-> terminal_o[1])
		else $error("allocated position done not on terminal");

	AST_ALL_OPEN: assert property (
		flags_o == 5'h00 |-> terminal_o == 3'h0)
		else $error("terminal closed with no flag asserted");

	COV_READY_ACCEPT: cover property (flags_o.ready ##1 servo_on_accept_o);
	COV_DONE_MODE2: cover property (flags_o.position_done && tm_act_q == TM_INPUT_ZERO);
	COV_SPD_MATCH_TERM: cover property (flags_o.speed_match && terminal_o != 3'h0);
	COV_ROT_DETECT: cover property (flags_o.rotation);
	COV_ENC_READY: cover property (flags_o.ready && pin2_q.abs_encoder);

endmodule : ssof_top

// ===== ssof_top_tb.sv
// Purpose: self-checking bench for the status flags block
// Assumes: register port and host model on mclk_i
// Notes: table rows cover thresholds, hand tests the rest
`timescale 1ns/1ns
module ssof_top_tb;
	import ssof_pkg::*;
	typedef struct {
		ssof_ctrl_mode_t mode;
		logic signed [15:0] motor;
		logic signed [15:0] refs;
		logic signed [31:0] err;
		logic [2:0] exp;
	} ssof_row_t;
	logic mclk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic [31:0] v;
	logic main_power = 1'b0, base_block = 1'b0, alarm = 1'b0, warning = 1'b0, abs_enc = 1'b0;
	logic enc_on, srv_on, step_go, accept;
	ssof_pins_t pins;
	logic signed [15:0] motor = 16'sh0, refs = 16'sh0;
	logic signed [31:0] err = 32'sh0, filt = 32'sh0, raw = 32'sh0;
	ssof_flags_t flags;
	logic [2:0] term;
	int fail_count = 0;
	int total_checks = 0;
	ssof_row_t rows [6] = '{
		'{CM_SPEED, 16'sh14, 16'sh1D, 32'sh0, 3'h6},
		'{CM_SPEED, 16'sh13, 16'sh1D, 32'sh0, 3'h0},
		'{CM_SPEED, -16'sh14, -16'sh14, 32'sh0, 3'h6},
		'{CM_POSITION, 16'sh0, 16'sh0, 32'sh6, 3'h1},
		'{CM_POSITION, 16'sh0, 16'sh0, -32'sh7, 3'h0},
		'{CM_TORQUE, 16'sh0, 16'sh0, 32'sh0, 3'h0}};
	assign pins = {main_power, base_block, alarm, warning, abs_enc, enc_on, srv_on};
	ssof_top u_dut (.mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
		.rd_i(rd), .rdata_o(rdata), .pins_i(pins), .motor_speed_i(motor), .ref_speed_i(refs),
		.position_error_i(err), .pos_ref_filtered_i(filt), .pos_ref_input_i(raw), .flags_o(flags),
		.servo_on_accept_o(accept), .terminal_o(term));
	ssof_host_model u_host (.mclk_i(mclk_i), .reset_i(reset_i), .flags_i(flags), .abs_encoder_i(abs_enc),
		.encoder_power_on_o(enc_on), .servo_on_o(srv_on), .step_go_o(step_go));
	// clock generator
	initial begin
		forever #5 mclk_i = ~mclk_i;
	end
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk_i);
		wr <= 1'b0;
	endtask : wreg
	task automatic rreg(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk_i);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rreg
	task automatic settle(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask : settle
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : wrap_up
	// watchdog
	initial begin
		repeat (3000) @(posedge mclk_i);
		fail_count++;
		wrap_up();
	end
	// main sequence
	initial begin
		repeat (2) @(posedge mclk_i);
		#1 chk("flags_in_rst", 32'h0, {term, accept, flags});
		@(posedge mclk_i);
		reset_i <= 1'b0;
		settle(1);
		// equal speeds in speed mode match at once
		chk("flags_rst", 32'h2, flags);
		rreg(OFS_ROT_LVL, v); chk("rot_lvl_rst", ROT_LVL_RST, v);
		rreg(OFS_SPD_W, v); chk("spd_w_rst", SPD_W_RST, v);
		rreg(OFS_POS_W, v); chk("pos_w_rst", POS_W_RST, v);
		rreg(OFS_TIMING, v); chk("timing_rst", 32'h0, v);
		rreg(8'h20, v); chk("unmapped", 32'h0, v);
		foreach (rows[i]) begin
			wreg(OFS_MODE, {30'h0, rows[i].mode});
			motor <= rows[i].motor;
			refs <= rows[i].refs;
			err <= rows[i].err;
			settle(2);
			chk("row_flags", rows[i].exp, {flags.rotation, flags.speed_match, flags.position_done});
		end
		// threshold clamps and immediate effect
		wreg(OFS_ROT_LVL, 32'h0); rreg(OFS_ROT_LVL, v); chk("rot_min", ROT_LVL_MIN, v);
		wreg(OFS_ROT_LVL, 32'h4E20); rreg(OFS_ROT_LVL, v); chk("rot_max", ROT_LVL_MAX, v);
		wreg(OFS_POS_W, 32'h4000_0001); rreg(OFS_POS_W, v); chk("pos_max", POS_W_MAX, v);
		wreg(OFS_POS_W, POS_W_RST);
		wreg(OFS_MODE, {30'h0, CM_SPEED});
		motor <= 16'sh0;
		refs <= 16'sh63;
		wreg(OFS_SPD_W, 32'hC8); rreg(OFS_SPD_W, v); chk("spd_max", SPD_W_MAX, v);
		settle(2); chk("spd_wide", 1'b1, flags.speed_match);
		settle(2); chk("interlock", 1'b1, step_go);
		// completion timing modes need the apply write
		wreg(OFS_MODE, {30'h0, CM_POSITION});
		err <= 32'sh0;
		filt <= 32'sh5;
		wreg(OFS_TIMING, {30'h0, TM_FILTERED_ZERO});
		settle(2); chk("done_pending", 1'b1, flags.position_done);
		wreg(OFS_APPLY, 32'h1);
		settle(2); chk("done_filt_busy", 1'b0, flags.position_done);
		@(posedge mclk_i);
		filt <= 32'sh0;
		raw <= 32'sh3;
		settle(2); chk("done_filt_zero", 1'b1, flags.position_done);
		wreg(OFS_TIMING, {30'h0, TM_INPUT_ZERO});
		wreg(OFS_APPLY, 32'h1);
		settle(2); chk("done_raw_busy", 1'b0, flags.position_done);
		@(posedge mclk_i);
		raw <= 32'sh0;
		settle(2); chk("done_raw_zero", 1'b1, flags.position_done);
		// value 3 is refused, registers keep their contents
		wreg(OFS_MODE, 32'h3);
		rreg(OFS_MODE, v);
		chk("mode_refused", 32'h1, v);
		wreg(OFS_TIMING, 32'h3);
		rreg(OFS_TIMING, v);
		chk("timing_refused", 32'h22, v);
		// warning and ready with terminal allocation
		wreg(OFS_ALLOC, 32'h231);
		warning <= 1'b1;
		settle(5); chk("warn_term", 3'h3, term);
		@(posedge mclk_i);
		main_power <= 1'b1;
		abs_enc <= 1'b1;
		settle(5); chk("ready_no_enc", 1'b0, flags.ready);
		settle(25); chk("ready_term", 3'h7, term);
		chk("accept", 1'b1, accept);
		// status word: terminals 7, accept, warning, ready and done
		rreg(OFS_STATUS, v);
		chk("status", 32'h1F5, v);
		@(posedge mclk_i);
		alarm <= 1'b1;
		settle(5); chk("ready_alarm", 1'b0, flags.ready);
		@(posedge mclk_i);
		alarm <= 1'b0;
		base_block <= 1'b1;
		settle(5); chk("ready_bb", 1'b0, flags.ready);
		chk("accept_off", 1'b0, accept);
		wreg(OFS_ALLOC, 32'h0);
		settle(2); chk("unalloc", 3'h0, term);
		@(posedge mclk_i);
		warning <= 1'b0;
		settle(5); chk("warn_off", 1'b0, flags.warning);
		// reset again in mid-run, registers and timing mode go back
		@(posedge mclk_i);
		reset_i <= 1'b1;
		@(posedge mclk_i);
		reset_i <= 1'b0;
		settle(1);
		chk("rst_again", 32'h0, {term, accept, flags});
		rreg(OFS_ROT_LVL, v);
		chk("rot_again", ROT_LVL_RST, v);
		rreg(OFS_TIMING, v);
		chk("timing_again", 32'h0, v);
		wrap_up();
	end
endmodule : ssof_top_tb
